// ===== verilog/cie_pkg.sv
package cie_pkg;

  // ************************************************************
  // Register map (index; byte address is four times the index)
  // ************************************************************
  localparam int unsigned   IDX_W        = 6;
  localparam logic [5:0]    IDX_PEND     = 6'h03;  // Pending flags, read clears all but receive
  localparam logic [5:0]    IDX_ENABLE   = 6'h04;  // Interrupt enables
  localparam logic [5:0]    IDX_ALC      = 6'h0b;  // Arbitration lost capture
  localparam int unsigned   IDX_LSB      = 2;      // Byte address to index shift

  // ************************************************************
  // Field positions inside the enable and pending registers
  // ************************************************************
  localparam int unsigned   BIT_BUS_ERR  = 7;
  localparam int unsigned   BIT_ARB_LOST = 6;
  localparam int unsigned   BIT_PASSIVE  = 5;
  localparam int unsigned   BIT_WAKE     = 4;
  localparam int unsigned   BIT_OVERRUN  = 3;
  localparam int unsigned   BIT_WARN     = 2;
  localparam int unsigned   BIT_TX       = 1;
  localparam int unsigned   BIT_RX       = 0;
  localparam int unsigned   POS_W        = 5;      // Capture field width

  // ************************************************************
  // Reset values and answers
  // ************************************************************
  localparam logic [7:0]    ENABLE_RST   = 8'h00;
  localparam logic [7:0]    PEND_RST     = 8'h00;
  localparam logic [4:0]    ALC_RST      = 5'h00;
  localparam logic [7:0]    FLAGS_NO_RX  = 8'hfe;  // Flags cleared by a pending read
  localparam logic [1:0]    RESP_OKAY    = 2'h0;
  localparam logic [1:0]    RESP_SLVERR  = 2'h2;

  // ************************************************************
  // Capture codes of the bit stream position
  // ************************************************************
  localparam logic [4:0]    CODE_ID11    = 5'h0a;  // Last base identifier bit
  localparam logic [4:0]    CODE_SRTR    = 5'h0b;  // SRTR, or RTR of a standard frame
  localparam logic [4:0]    CODE_IDE     = 5'h0c;
  localparam logic [4:0]    CODE_EXT_MIN = 5'h0d;  // First extended-only code
  localparam logic [4:0]    CODE_RTR_EXT = 5'h1f;

endpackage

// ===== verilog/cie_reg_if.sv
`timescale 1ns/10ps
// Register access strobes between the bus slave and the core
interface cie_reg_if;
  logic                       wr_en;
  logic [cie_pkg::IDX_W-1:0]  wr_idx;
  logic [7:0]                 wr_data;
  logic                       wr_hit;
  logic                       rd_en;
  logic [cie_pkg::IDX_W-1:0]  rd_idx;
  logic [7:0]                 rd_data;
  logic                       rd_hit;

  modport slv (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
               input wr_hit, rd_data, rd_hit);
  modport core (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface

// ===== verilog/cie_axil_slave.sv
`timescale 1ns/10ps
module cie_axil_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  cie_reg_if.slv                 regs
);

  typedef struct packed {
    logic                      aw_got;
    logic [cie_pkg::IDX_W-1:0] aw_idx;
    logic                      w_got;
    logic [7:0]                w_byte;
    logic                      w_lane;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      ar_got;
    logic [cie_pkg::IDX_W-1:0] ar_idx;
    logic                      arready;
    logic                      rvalid;
    logic [7:0]                rdata;
    logic [1:0]                rresp;
  } cie_slv_t;

  cie_slv_t s;
  cie_slv_t next_s;

  // Byte address to register index; unaligned addresses have no index
  function automatic logic [cie_pkg::IDX_W:0] cie_addr_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a >> cie_pkg::IDX_LSB;
    cie_addr_idx = {(a[cie_pkg::IDX_LSB-1:0] == 2'h0), w[cie_pkg::IDX_W-1:0]};
  endfunction

  logic [cie_pkg::IDX_W:0] aw_dec;
  logic [cie_pkg::IDX_W:0] ar_dec;

  // Strobes to the core, in the first cycle that both halves are held; the write strobe only if byte lane 0 is set
  assign aw_dec       = cie_addr_idx(awaddr);
  assign ar_dec       = cie_addr_idx(araddr);
  assign regs.wr_en   = s.aw_got && s.w_got && !s.bvalid && s.w_lane;
  assign regs.wr_idx  = s.aw_idx;
  assign regs.wr_data = s.w_byte;
  assign regs.rd_en   = s.ar_got && !s.rvalid;
  assign regs.rd_idx  = s.ar_idx;

  // Channel handshakes and answers
  always_comb begin
    next_s = s;
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = aw_dec[cie_pkg::IDX_W] ? aw_dec[cie_pkg::IDX_W-1:0] : '1;
    end
    if (wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.w_byte = wdata[7:0];
      next_s.w_lane = wstrb[0];
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = regs.wr_hit ? cie_pkg::RESP_OKAY : cie_pkg::RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.ar_got = 1'b1;
      next_s.ar_idx = ar_dec[cie_pkg::IDX_W] ? ar_dec[cie_pkg::IDX_W-1:0] : '1;
    end
    if (regs.rd_en) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = regs.rd_data;
      next_s.rresp  = regs.rd_hit ? cie_pkg::RESP_OKAY : cie_pkg::RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.ar_got = 1'b0;
    end
    next_s.awready = !next_s.aw_got;
    next_s.wready  = !next_s.w_got;
    next_s.arready = !next_s.ar_got;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = {24'h000000, s.rdata};

endmodule

// ===== verilog/cie_irq_core.sv
`timescale 1ns/10ps
// Function
// - Sleep try while busy or pending raises wake
// - Receive flag tracks buffer, survives pending read
// - Release command blanks receive flag one cycle
// - Enable register, eight bits, read and write
// - Bus error sets flag when enabled
// - Arbitration loss sets flag when enabled
// - Passive state change sets flag when enabled
// - Wake-up from sleep sets flag when enabled
// - Overrun rising edge sets flag when enabled
// - Error or bus status change sets flag when enabled
// - Transmit buffer release sets flag when enabled
// - Receive flag while buffer full and enabled
// - Clearing receive enable drops flag, and pin if no other flag set
// - Capture register read-only, upper bits zero
// - Arbitration loss captures five-bit position
// - Capture frozen until read, then rearmed
// - Pending read clears arbitration lost flag
// - No new arbitration flag before capture read
// - Codes 0-10 are identifier bits 1-11
// - Code 11 SRTR, code 12 IDE
// - Codes 13-30 identifier 12-29, 31 RTR
// - Extended-only codes above 12; standard RTR 11
// - Interrupt pin low while any flag set
module cie_irq_core #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite register port
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Event and status inputs from the controller logic
  input  wire logic              bus_err_evt,
  input  wire logic              arb_lost_evt,
  input  wire logic [4:0]        arb_bit_pos,
  input  wire logic              err_passive,
  input  wire logic              asleep,
  input  wire logic              bus_activity,
  input  wire logic              sleep_try,
  input  wire logic              bus_involved,
  input  wire logic              data_overrun,
  input  wire logic              err_status,
  input  wire logic              bus_status,
  input  wire logic              tx_buf_free,
  input  wire logic              rx_buf_full,
  input  wire logic              release_rx_cmd,
  // Host side
  output      logic              irq_n,
  output      logic [7:0]        pending_flags
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]  irq_enable_reg;
    logic [7:0]  ir;
    logic [4:0]  arb_loss_capture;
    logic        alc_armed;
    logic        primed;
    logic        pas_q;
    logic        dovr_q;
    logic        err_q;
    logic        bus_q;
    logic        txb_q;
    logic        irq_n;
  } cie_core_t;

  cie_core_t s;
  cie_core_t next_s;
  logic [7:0] set_vec;
  logic [7:0] next_ier;
  logic       rd_pend;
  logic       rd_alc;

  cie_reg_if regs ();

  // ************************************************************
  // Bus slave
  // ************************************************************
  cie_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs)
  );

  // ************************************************************
  // Register decode
  // ************************************************************
  // Only the enable register accepts writes; read-only ones ignore them
  assign regs.wr_hit = (regs.wr_idx == cie_pkg::IDX_ENABLE) ||
                       (regs.wr_idx == cie_pkg::IDX_PEND) ||
                       (regs.wr_idx == cie_pkg::IDX_ALC);
  assign regs.rd_hit = (regs.rd_idx == cie_pkg::IDX_ENABLE) ||
                       (regs.rd_idx == cie_pkg::IDX_PEND) ||
                       (regs.rd_idx == cie_pkg::IDX_ALC);
  assign rd_pend     = regs.rd_en && (regs.rd_idx == cie_pkg::IDX_PEND);
  assign rd_alc      = regs.rd_en && (regs.rd_idx == cie_pkg::IDX_ALC);

  // Read data, taken before any read side effect
  always_comb begin
    case (regs.rd_idx)
      cie_pkg::IDX_ENABLE: regs.rd_data = s.irq_enable_reg;
      cie_pkg::IDX_PEND:   regs.rd_data = s.ir;
      cie_pkg::IDX_ALC:    regs.rd_data = {3'h0, s.arb_loss_capture};
      default:             regs.rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_ier = s.irq_enable_reg;
    if (regs.wr_en && (regs.wr_idx == cie_pkg::IDX_ENABLE)) begin
      next_ier = regs.wr_data;
    end
  end

  // ************************************************************
  // Flag set sources
  // ************************************************************
  always_comb begin
    set_vec = 8'h00;
    set_vec[cie_pkg::BIT_BUS_ERR]  = bus_err_evt && s.irq_enable_reg[cie_pkg::BIT_BUS_ERR];
    // arbitration loss, blocked while capture unread
    set_vec[cie_pkg::BIT_ARB_LOST] = arb_lost_evt && s.alc_armed &&
                                     s.irq_enable_reg[cie_pkg::BIT_ARB_LOST];
    set_vec[cie_pkg::BIT_PASSIVE]  = s.primed && (err_passive != s.pas_q) &&
                                     s.irq_enable_reg[cie_pkg::BIT_PASSIVE];
    // wake-up, and sleep try while busy
    set_vec[cie_pkg::BIT_WAKE]     = s.irq_enable_reg[cie_pkg::BIT_WAKE] &&
                                     ((asleep && bus_activity) ||
                                      (sleep_try && (bus_involved || (|s.ir))));
    set_vec[cie_pkg::BIT_OVERRUN]  = s.primed && data_overrun && !s.dovr_q &&
                                     s.irq_enable_reg[cie_pkg::BIT_OVERRUN];
    set_vec[cie_pkg::BIT_WARN]     = s.primed && ((err_status != s.err_q) ||
                                     (bus_status != s.bus_q)) &&
                                     s.irq_enable_reg[cie_pkg::BIT_WARN];
    set_vec[cie_pkg::BIT_TX]       = s.primed && tx_buf_free && !s.txb_q &&
                                     s.irq_enable_reg[cie_pkg::BIT_TX];
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s        = s;
    next_s.irq_enable_reg    = next_ier;
    next_s.primed = 1'b1;
    next_s.pas_q  = err_passive;
    next_s.dovr_q = data_overrun;
    next_s.err_q  = err_status;
    next_s.bus_q  = bus_status;
    next_s.txb_q  = tx_buf_free;
    // pending read clears all but receive; sets win
    if (rd_pend) begin
      next_s.ir = s.ir & ~cie_pkg::FLAGS_NO_RX;
    end
    next_s.ir = next_s.ir | set_vec;
    // receive flag follows buffer, gated new enable at once
    // release blanks it for one cycle
    next_s.ir[cie_pkg::BIT_RX] = rx_buf_full && next_ier[cie_pkg::BIT_RX] &&
                                 !release_rx_cmd;
    // read of the capture rearms it
    if (rd_alc) begin
      next_s.alc_armed = 1'b1;
    end
    if (arb_lost_evt && s.alc_armed) begin
      next_s.arb_loss_capture       = arb_bit_pos;
      next_s.alc_armed = 1'b0;
    end
    // pin low while any flag set
    next_s.irq_n = ~(|next_s.ir);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s           <= '0;
      s.irq_enable_reg       <= cie_pkg::ENABLE_RST;
      s.ir        <= cie_pkg::PEND_RST;
      s.arb_loss_capture       <= cie_pkg::ALC_RST;
      s.alc_armed <= 1'b1;
      s.irq_n     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign irq_n         = s.irq_n;
  assign pending_flags = s.ir;

  // ************************************************************
  // Checks
  // ************************************************************
  // bus error
  a_bus_err_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (bus_err_evt && s.irq_enable_reg[cie_pkg::BIT_BUS_ERR]) |=> s.ir[cie_pkg::BIT_BUS_ERR])
    else $error("bus error flag not set");

  a_bus_err_off:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (!s.irq_enable_reg[cie_pkg::BIT_BUS_ERR] && !s.ir[cie_pkg::BIT_BUS_ERR])
      |=> !s.ir[cie_pkg::BIT_BUS_ERR])
    else $error("bus error flag set while disabled");

  a_arb_flag_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_lost_evt && s.alc_armed && s.irq_enable_reg[cie_pkg::BIT_ARB_LOST])
      |=> s.ir[cie_pkg::BIT_ARB_LOST])
    else $error("arbitration flag not set");

  a_arb_blocked:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (!s.alc_armed && !s.ir[cie_pkg::BIT_ARB_LOST]) |=> !s.ir[cie_pkg::BIT_ARB_LOST])
    else $error("arbitration flag before capture read");

  a_alc_capture:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (arb_lost_evt && s.alc_armed) |=> (s.arb_loss_capture == $past(arb_bit_pos)) && !s.alc_armed)
    else $error("position not captured");

  a_alc_frozen:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (!s.alc_armed && !rd_alc) [*2] |-> $stable(s.arb_loss_capture))
    else $error("capture changed while frozen");

  a_alc_rearm:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_alc && !arb_lost_evt) |=> s.alc_armed)
    else $error("capture not rearmed after read");

  a_pend_clear:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_pend && (set_vec == 8'h00)) |=> (s.ir & cie_pkg::FLAGS_NO_RX) == 8'h00)
    else $error("pending read did not clear flags");

  a_rx_follow:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_buf_full && next_ier[cie_pkg::BIT_RX] && !release_rx_cmd)
      |=> s.ir[cie_pkg::BIT_RX])
    else $error("receive flag not following buffer");

  a_rx_release:
  assert property (@(posedge aclk) disable iff (!aresetn)
    release_rx_cmd |=> !s.ir[cie_pkg::BIT_RX])
    else $error("receive flag not blanked by release");

  a_rx_enable_off:
  assert property (@(posedge aclk) disable iff (!aresetn)
    !s.irq_enable_reg[cie_pkg::BIT_RX] |-> !s.ir[cie_pkg::BIT_RX])
    else $error("receive flag set while disabled");

  a_wake_sleep_try:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_try && s.irq_enable_reg[cie_pkg::BIT_WAKE] && (bus_involved || (|s.ir)))
      |=> s.ir[cie_pkg::BIT_WAKE])
    else $error("wake flag not set on sleep try");

  a_warn_change:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (s.primed && s.irq_enable_reg[cie_pkg::BIT_WARN] && $changed(err_status))
      |-> ##1 s.ir[cie_pkg::BIT_WARN])
    else $error("warning flag missed status change");

  a_irq_pin:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.irq_n == (s.ir == 8'h00))
    else $error("interrupt pin disagrees with flags");

  a_tx_edge_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (s.primed && tx_buf_free && !s.txb_q && s.irq_enable_reg[cie_pkg::BIT_TX]) |=> s.ir[cie_pkg::BIT_TX])
    else $error("transmit flag not set");

  a_ovr_edge_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (s.primed && data_overrun && !s.dovr_q && s.irq_enable_reg[cie_pkg::BIT_OVERRUN])
      |=> s.ir[cie_pkg::BIT_OVERRUN])
    else $error("overrun flag not set");

  a_passive_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (s.primed && (err_passive != s.pas_q) && s.irq_enable_reg[cie_pkg::BIT_PASSIVE])
      |=> s.ir[cie_pkg::BIT_PASSIVE])
    else $error("passive flag not set");

  a_wake_set:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (asleep && bus_activity && s.irq_enable_reg[cie_pkg::BIT_WAKE]) |=> s.ir[cie_pkg::BIT_WAKE])
    else $error("wake flag not set");

  a_alc_upper_zero:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rd_alc |-> (regs.rd_data[7:5] == 3'h0))
    else $error("capture reserved bits not zero");

  a_rx_gate:
  assert property (@(posedge aclk) disable iff (!aresetn)
    !next_ier[cie_pkg::BIT_RX] |=> !s.ir[cie_pkg::BIT_RX])
    else $error("receive flag set without enable");

  a_irq_release:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (regs.wr_en && (regs.wr_idx == cie_pkg::IDX_ENABLE) && !regs.wr_data[cie_pkg::BIT_RX] &&
     ((s.ir & cie_pkg::FLAGS_NO_RX) == 8'h00) && (set_vec == 8'h00)) |=> s.irq_n)
    else $error("interrupt pin not released");

endmodule

// ===== tb/cie_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// Host processor model: AXI4-Lite master
// ************************************************************
module cie_host_model (
  input  wire logic        aclk,
  output      logic [7:0]  awaddr,
  output      logic        awvalid,
  input  wire logic        awready,
  output      logic [31:0] wdata,
  output      logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output      logic        bready,
  output      logic [7:0]  araddr,
  output      logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output      logic        rready
);
  int slow = 0;  // Stall cycles before taking an answer

  // Quiet bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Write: address and data offered together, payload scrambled on release
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
      end
    end
    repeat (slow) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    #1;
  endtask

  // Read: one word, answer taken at the handshake edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    repeat (slow) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    #1;
  endtask
endmodule

// ===== tb/can_irq_enable_arb_capture_test.sv
`timescale 1ns/10ps
module can_irq_enable_arb_capture_test;
  // Event vector bits
  localparam logic [12:0] BE = 13'h1000, AL = 13'h0800, EP = 13'h0400, SL = 13'h0200,
    BA = 13'h0100, ST = 13'h0080, BI = 13'h0040, DO = 13'h0020, ES = 13'h0010,
    TF = 13'h0004, RF = 13'h0002, RL = 13'h0001;
  localparam logic [7:0] A_PEND = 8'h0c, A_EN = 8'h10, A_ALC = 8'h2c;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [12:0] ev = 13'h0;
  logic [4:0]  pos = 5'h00;
  logic [7:0]  awaddr, araddr, pflags, d;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq_n;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [12:0] src [1:7] = '{TF, ES, DO, SL | BA, EP, AL, BE};
  logic [4:0]  codes [7] = '{5'h00, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h1e, 5'h1f};

  // 200 MHz clock
  initial forever #2.5 aclk = ~aclk;

  cie_irq_core u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_err_evt(ev[12]),
    .arb_lost_evt(ev[11]), .arb_bit_pos(pos), .err_passive(ev[10]), .asleep(ev[9]),
    .bus_activity(ev[8]), .sleep_try(ev[7]), .bus_involved(ev[6]),
    .data_overrun(ev[5]), .err_status(ev[4]), .bus_status(ev[3]),
    .tx_buf_free(ev[2]), .rx_buf_full(ev[1]), .release_rx_cmd(ev[0]),
    .irq_n(irq_n), .pending_flags(pflags));

  cie_host_model u_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  // Drive events and hold them until the next step, then let the edge land
  task automatic step(input logic [12:0] v);
    ev <= v;
    @(posedge aclk);
    #1;
  endtask

  // Flags and the interrupt pin together
  task automatic fl(input logic [7:0] e);
    chk(pflags, e);
    chk(8'(irq_n), 8'(e == 8'h00));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d, r);
    chk(d, e);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    fl(8'h00);
    rchk(A_EN, 8'h00);
    rchk(A_ALC, 8'h00);
    done("reset");
    u_host.slow = 3;
    u_host.wr(A_EN, 8'ha4, r);
    chk(8'(r), 8'(cie_pkg::RESP_OKAY));
    rchk(A_EN, 8'ha4);
    u_host.slow = 0;
    u_host.wr(A_ALC, 8'hff, r);
    chk(8'(r), 8'(cie_pkg::RESP_OKAY));
    rchk(A_ALC, 8'h00);
    u_host.wr(A_PEND, 8'hff, r);
    fl(8'h00);
    u_host.rd(8'h40, d, r);
    chk(8'(r), 8'(cie_pkg::RESP_SLVERR));
    done("registers");
    // Each source but receive first disabled, then enabled alone
    for (int i = 1; i < 8; i++) begin
      u_host.wr(A_EN, 8'h00, r);
      step(src[i]);
      step(13'h0);
      fl(8'h00);
      u_host.rd(A_ALC, d, r);
      u_host.wr(A_EN, 8'h01 << i, r);
      step(src[i]);
      step(13'h0);
      fl(8'h01 << i);
      rchk(A_PEND, 8'h01 << i);
      fl(8'h00);
      u_host.rd(A_ALC, d, r);
    end
    done("sources");
    u_host.wr(A_EN, 8'h12, r);
    step(ST);
    step(13'h0);
    fl(8'h00);
    step(ST | BI);
    step(13'h0);
    fl(8'h10);
    u_host.rd(A_PEND, d, r);
    step(TF);
    step(ST);
    step(13'h0);
    fl(8'h12);
    u_host.rd(A_PEND, d, r);
    done("sleep");
    u_host.wr(A_EN, 8'h01, r);
    step(RF);
    fl(8'h01);
    rchk(A_PEND, 8'h01);
    fl(8'h01);
    step(RF | RL);
    fl(8'h00);
    step(RF);
    fl(8'h01);
    u_host.wr(A_EN, 8'h00, r);
    fl(8'h00);
    u_host.wr(A_EN, 8'h01, r);
    step(RL);
    step(13'h0);
    fl(8'h00);
    done("receive");
    u_host.wr(A_EN, 8'h40, r);
    foreach (codes[k]) begin
      pos <= codes[k];
      step(AL);
      pos <= ~codes[k];
      step(AL);
      step(13'h0);
      fl(8'h40);
      u_host.rd(A_PEND, d, r);
      step(AL);
      step(13'h0);
      fl(8'h00);
      rchk(A_ALC, {3'h0, codes[k]});
    end
    done("capture");
    results();
  end
endmodule
